// File: design/tcp_pkg.sv
package tcp_pkg;

  // ************************************************************
  // widths
  // ************************************************************
  localparam int DUTY_W = 10;
  localparam int BYTE_W = 8;
  localparam int Q_W = 2;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int NUM_CH = 3;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int TOSC_NS = 10;
  localparam int Q_PER_CYCLE = 4;
  localparam int TIMER_TICK_CYC = (Q_PER_CYCLE * TOSC_NS) / TOSC_NS;
  localparam logic [Q_W-1:0] Q_LAST = Q_W'(TIMER_TICK_CYC - 1);
  localparam logic [Q_W-1:0] Q_ONE = 2'h1;

  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [ADDR_W-1:0] OFF_CH1_DUTY_HIGH = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_CH1_DUTY_LOW = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_CH2_DUTY_HIGH = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_CH2_DUTY_LOW = 6'h0C;
  localparam logic [ADDR_W-1:0] OFF_CH3_DUTY_HIGH = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_CH3_DUTY_LOW = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_PERIOD_A = 6'h18;
  localparam logic [ADDR_W-1:0] OFF_PERIOD_B = 6'h1C;
  localparam logic [ADDR_W-1:0] OFF_TIMER_A = 6'h20;
  localparam logic [ADDR_W-1:0] OFF_TIMER_B = 6'h24;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 6'h28;
  localparam logic [ADDR_W-1:0] OFF_INT_STATUS = 6'h2C;
  localparam logic [ADDR_W-1:0] OFF_INT_MASK = 6'h30;
  localparam logic [ADDR_W-1:0] CH_STRIDE = 6'h08;
  localparam logic [ADDR_W-1:0] LOW_STEP = 6'h04;

  // ************************************************************
  // fields and reset values
  // ************************************************************
  localparam int DUTY_LO_MSB = 7;
  localparam int DUTY_LO_LSB = 6;
  localparam int SEL_BIT = 5;
  localparam int CTRL_TA_ON = 0;
  localparam int CTRL_TB_ON = 1;
  localparam int CTRL_CASCADE = 2;
  localparam int CTRL_EN_LSB = 3;
  localparam int CTRL_W = 6;
  localparam int STAT_TA = 0;
  localparam int STAT_TB = 1;
  localparam int STAT_W = 2;
  localparam logic [BYTE_W-1:0] PERIOD_RST = 8'hFF;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
  localparam logic [STAT_W-1:0] STAT_ZERO = 2'h0;
  localparam logic [DUTY_W-1:0] DUTY_ZERO = 10'h000;

endpackage : tcp_pkg

// File: design/tcp_tmr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tcp_tmr_if;
  import tcp_pkg::*;
  logic roll;
  logic [DUTY_W-1:0] cnt_nxt;
  logic [BYTE_W-1:0] count;
  modport src (output roll, output cnt_nxt, output count);
  modport snk (input roll, input cnt_nxt, input count);
endinterface : tcp_tmr_if
`default_nettype wire

// File: design/tcp_timer.sv
`timescale 1ns/1ps
`default_nettype none
module tcp_timer import tcp_pkg::*; (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic run,
  input wire logic inc_en,
  input wire logic [Q_W-1:0] q_nxt,
  input wire logic [BYTE_W-1:0] period,
  tcp_tmr_if.src tmr
);

  logic [BYTE_W-1:0] count_r;
  logic [BYTE_W-1:0] count_nxt;
  logic step;

  // ************************************************************
  // count and rollover
  // ************************************************************
  assign step = run & inc_en;
  assign tmr.roll = step & (count_r == period);

  always_comb begin
    if (tmr.roll) begin
      count_nxt = BYTE_ZERO;
    end else if (step) begin
      count_nxt = count_r + 8'h01;
    end else begin
      count_nxt = count_r;
    end
  end

  // combined timer and q phase of the next cycle
  assign tmr.cnt_nxt = tmr.roll ? DUTY_ZERO : {count_nxt, q_nxt};
  assign tmr.count = count_r;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      count_r <= BYTE_ZERO;
    end else begin
      count_r <= count_nxt;
    end
  end

endmodule : tcp_timer
`default_nettype wire

// File: design/tcp_channel.sv
`timescale 1ns/1ps
`default_nettype none
module tcp_channel import tcp_pkg::*; (
  input wire logic ref_clk,
  input wire logic reset,
  tcp_tmr_if.snk ta,
  tcp_tmr_if.snk tb,
  input wire logic sel_allowed,
  input wire logic enable,
  input wire logic wr_hi,
  input wire logic wr_lo,
  input wire logic [BYTE_W-1:0] wdata,
  output logic [BYTE_W-1:0] rd_hi,
  output logic [BYTE_W-1:0] rd_lo,
  output logic pwm_out
);

  logic [BYTE_W-1:0] hi_m_r;
  logic [1:0] lo_m_r;
  logic sel_m_r;
  logic [BYTE_W-1:0] hi_s_r;
  logic [1:0] lo_s_r;
  logic sel_s_r;
  logic sel;
  logic roll;
  logic [DUTY_W-1:0] cnt;
  logic [DUTY_W-1:0] duty_m;
  logic [DUTY_W-1:0] duty_s;

  // ************************************************************
  // timebase choice
  // ************************************************************
  assign sel = sel_allowed & sel_m_r;
  assign roll = sel ? tb.roll : ta.roll;
  assign cnt = sel ? tb.cnt_nxt : ta.cnt_nxt;
  assign duty_m = {hi_m_r, lo_m_r};
  assign duty_s = {hi_s_r, lo_s_r};

  // ************************************************************
  // master and slave latches
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hi_m_r <= BYTE_ZERO;
      lo_m_r <= '0;
      sel_m_r <= 1'b0;
    end else begin
      if (wr_hi) begin
        hi_m_r <= wdata;
      end
      if (wr_lo) begin
        lo_m_r <= wdata[DUTY_LO_MSB:DUTY_LO_LSB];
        sel_m_r <= wdata[SEL_BIT];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hi_s_r <= BYTE_ZERO;
      lo_s_r <= '0;
      sel_s_r <= 1'b0;
    end else if (roll) begin
      hi_s_r <= hi_m_r;
      lo_s_r <= lo_m_r;
      sel_s_r <= sel_m_r;
    end
  end

  // reads see only the slave copy
  assign rd_hi = hi_s_r;
  assign rd_lo = {lo_s_r, sel_s_r, {SEL_BIT{1'b0}}};

  // ************************************************************
  // output
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pwm_out <= 1'b0;
    end else if (!enable) begin
      pwm_out <= 1'b0;
    end else if (roll) begin
      pwm_out <= (duty_m != DUTY_ZERO);
    end else if (cnt >= duty_s) begin
      pwm_out <= 1'b0;
    end
  end

endmodule : tcp_channel
`default_nettype wire

// File: design/tcp_top.sv
// The placing of the registers and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - channel one always runs from timer_a and period_reg_a
// - channel two uses timer_b when its select bit five is set
// - channel three uses timer_b when its select bit five is set
// - period is (period register plus one) times four clocks
// - timers never cascade while any channel is enabled
// - duty is high byte and low register bits seven to six
// - high time equals duty in clock periods
// - zero duty keeps the output low
// - high byte equal to period gives one to four low clocks
// - high byte above period gives full high output
// - writes land in master; rollover copies to slave, output high if duty nonzero
// - duty reads return the slave copy
// - timer equal to period clears on next step, flags new cycle
// - timer flags stay set until software clears them
module tcp_top import tcp_pkg::*; (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  output logic [DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  output logic pwm_out_1,
  output logic pwm_out_2,
  output logic pwm_out_3,
  output logic irq
);

  // ************************************************************
  // decode helpers
  // ************************************************************
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  function automatic logic [ADDR_W-1:0] hi_off(input int ch);
    hi_off = OFF_CH1_DUTY_HIGH + ADDR_W'(ch) * CH_STRIDE;
  endfunction : hi_off

  logic [Q_W-1:0] q_r;
  logic [Q_W-1:0] q_nxt;
  logic qtick;
  logic [BYTE_W-1:0] period_a_r;
  logic [BYTE_W-1:0] period_b_r;
  logic [CTRL_W-1:0] ctrl_r;
  logic [STAT_W-1:0] status_r;
  logic [STAT_W-1:0] mask_r;
  logic [STAT_W-1:0] stat_set;
  logic [STAT_W-1:0] stat_clr;
  logic wait_r;
  logic wr_go;
  logic rd_go;
  logic any_pwm;
  logic cascade_eff;
  logic [DATA_W-1:0] rd_mux;
  logic [NUM_CH-1:0] ch_out;
  logic [NUM_CH-1:0] ch_wr_hi;
  logic [NUM_CH-1:0] ch_wr_lo;
  logic [BYTE_W-1:0] ch_rd_hi [NUM_CH];
  logic [BYTE_W-1:0] ch_rd_lo [NUM_CH];

  tcp_tmr_if tmr_a ();
  tcp_tmr_if tmr_b ();

  // ************************************************************
  // q phase divider, one timer step every four clocks
  // ************************************************************
  assign qtick = (q_r == Q_LAST);
  assign q_nxt = q_r + Q_ONE;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ************************************************************
  // timers
  // ************************************************************
  assign any_pwm = |ctrl_r[CTRL_EN_LSB +: NUM_CH];
  assign cascade_eff = ctrl_r[CTRL_CASCADE] & ~any_pwm;

  tcp_timer u_timer_a (
    .ref_clk(ref_clk),
    .reset(reset),
    .run(ctrl_r[CTRL_TA_ON]),
    .inc_en(qtick),
    .q_nxt(q_nxt),
    .period(period_a_r),
    .tmr(tmr_a.src)
  );

  tcp_timer u_timer_b (
    .ref_clk(ref_clk),
    .reset(reset),
    .run(ctrl_r[CTRL_TB_ON]),
    .inc_en(cascade_eff ? tmr_a.roll : qtick),
    .q_nxt(q_nxt),
    .period(period_b_r),
    .tmr(tmr_b.src)
  );

  // ************************************************************
  // channels
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      assign ch_wr_hi[gi] = wr_go & hit(avs_address, hi_off(gi));
      assign ch_wr_lo[gi] = wr_go & hit(avs_address, hi_off(gi) + LOW_STEP);
      tcp_channel u_ch (
        .ref_clk(ref_clk),
        .reset(reset),
        .ta(tmr_a.snk),
        .tb(tmr_b.snk),
        .sel_allowed(gi != 0),
        .enable(ctrl_r[CTRL_EN_LSB + gi]),
        .wr_hi(ch_wr_hi[gi]),
        .wr_lo(ch_wr_lo[gi]),
        .wdata(avs_writedata[BYTE_W-1:0]),
        .rd_hi(ch_rd_hi[gi]),
        .rd_lo(ch_rd_lo[gi]),
        .pwm_out(ch_out[gi])
      );
    end
  endgenerate

  assign pwm_out_1 = ch_out[0];
  assign pwm_out_2 = ch_out[1];
  assign pwm_out_3 = ch_out[2];

  // ************************************************************
  // avalon slave handshake, one wait cycle per access
  // ************************************************************
  assign wr_go = avs_write & ~wait_r;
  assign rd_go = avs_read & ~wait_r;
  assign avs_waitrequest = wait_r;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wait_r <= 1'b1;
    end else if (wait_r && (avs_read || avs_write)) begin
      wait_r <= 1'b0;
    end else begin
      wait_r <= 1'b1;
    end
  end

  always_comb begin
    rd_mux = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (hit(avs_address, hi_off(i))) begin
        rd_mux[BYTE_W-1:0] = ch_rd_hi[i];
      end
      if (hit(avs_address, hi_off(i) + LOW_STEP)) begin
        rd_mux[BYTE_W-1:0] = ch_rd_lo[i];
      end
    end
    if (hit(avs_address, OFF_PERIOD_A)) begin
      rd_mux[BYTE_W-1:0] = period_a_r;
    end
    if (hit(avs_address, OFF_PERIOD_B)) begin
      rd_mux[BYTE_W-1:0] = period_b_r;
    end
    if (hit(avs_address, OFF_TIMER_A)) begin
      rd_mux[BYTE_W-1:0] = tmr_a.count;
    end
    if (hit(avs_address, OFF_TIMER_B)) begin
      rd_mux[BYTE_W-1:0] = tmr_b.count;
    end
    if (hit(avs_address, OFF_CTRL)) begin
      rd_mux[CTRL_W-1:0] = ctrl_r;
    end
    if (hit(avs_address, OFF_INT_STATUS)) begin
      rd_mux[STAT_W-1:0] = status_r;
    end
    if (hit(avs_address, OFF_INT_MASK)) begin
      rd_mux[STAT_W-1:0] = mask_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      avs_readdata <= '0;
    end else if (wait_r && avs_read) begin
      avs_readdata <= rd_mux;
    end
  end

  // ************************************************************
  // configuration registers
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      period_a_r <= PERIOD_RST;
      period_b_r <= PERIOD_RST;
    end else begin
      if (wr_go && hit(avs_address, OFF_PERIOD_A)) begin
        period_a_r <= avs_writedata[BYTE_W-1:0];
      end
      if (wr_go && hit(avs_address, OFF_PERIOD_B)) begin
        period_b_r <= avs_writedata[BYTE_W-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_r <= CTRL_RST;
      mask_r <= STAT_ZERO;
    end else begin
      if (wr_go && hit(avs_address, OFF_CTRL)) begin
        ctrl_r <= avs_writedata[CTRL_W-1:0];
      end
      if (wr_go && hit(avs_address, OFF_INT_MASK)) begin
        mask_r <= avs_writedata[STAT_W-1:0];
      end
    end
  end

  // ************************************************************
  // timer flags and interrupt
  // ************************************************************
  always_comb begin
    stat_set = STAT_ZERO;
    stat_set[STAT_TA] = tmr_a.roll;
    stat_set[STAT_TB] = tmr_b.roll;
  end

  assign stat_clr = (rd_go && hit(avs_address, OFF_INT_STATUS)) ? ~STAT_ZERO : STAT_ZERO;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      status_r <= STAT_ZERO;
    end else begin
      status_r <= (status_r & ~stat_clr) | stat_set;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_r & mask_r);
    end
  end

endmodule : tcp_top
`default_nettype wire

// File: tb/tcp_top_props.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// port checker
// ****************
module tcp_props import tcp_pkg::*; (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic pwm_out_1,
  input wire logic pwm_out_2,
  input wire logic pwm_out_3,
  input wire logic irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic done;
  logic rd_done;
  assign done = !avs_waitrequest;
  assign rd_done = avs_read && done;
  chk_req_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> done)
    else $error("request not answered");
  chk_wait_one: assert property (done |=> !done)
    else $error("wait low too long");
  chk_wait_cause: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
    else $error("wait low without request");
  chk_unmapped_zero: assert property (rd_done && avs_address > OFF_INT_MASK |-> avs_readdata == '0)
    else $error("unmapped read not zero");
  chk_duty_field: assert property (
    rd_done && avs_address < OFF_PERIOD_A && avs_address[2] |->
    avs_readdata[4:0] == 5'h00 && avs_readdata[31:8] == 24'h000000)
    else $error("duty low read has stray bits");
  chk_mask_off: assert property (
    avs_write && done && avs_address == OFF_INT_MASK && avs_writedata[1:0] == 2'h0 |-> ##2 !irq)
    else $error("irq with all masked");
  chk_off_low: assert property (
    avs_write && done && avs_address == OFF_CTRL && avs_writedata[5:3] == 3'h0 |->
    ##2 !(pwm_out_1 || pwm_out_2 || pwm_out_3))
    else $error("disabled output high");
  chk_rise_gap: assert property ($rose(pwm_out_1) |=> (!$rose(pwm_out_1)) [*3])
    else $error("period shorter than four clocks");
  chk_rdata_hold: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data changed");
  chk_reset_quiet: assert property ($fell(reset) |->
    !pwm_out_1 && !pwm_out_2 && !pwm_out_3 && !irq && avs_waitrequest)
    else $error("outputs active after reset");
  cover property (rd_done && avs_address == OFF_INT_STATUS && avs_readdata[1:0] == 2'h3);
  cover property ($rose(pwm_out_2));
  cover property ($rose(irq));
endmodule : tcp_props
bind tcp_top tcp_props u_props (.ref_clk(ref_clk), .reset(reset), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pwm_out_1(pwm_out_1),
  .pwm_out_2(pwm_out_2), .pwm_out_3(pwm_out_3), .irq(irq));
`default_nettype wire

// File: tb/tcp_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tcp_tb_top import tcp_pkg::*;;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [DATA_W-1:0] avs_writedata = '0;
  logic [DATA_W-1:0] avs_readdata;
  logic avs_waitrequest;
  logic [2:0] pwm;
  logic irq;
  logic [DATA_W-1:0] rd;
  int errors = 0;
  int num_checks = 0;
  always #5 ref_clk = ~ref_clk;
  tcp_top DUT (.ref_clk(ref_clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pwm_out_1(pwm[0]),
    .pwm_out_2(pwm[1]), .pwm_out_3(pwm[2]), .irq(irq));
  // ****************
  // helpers
  // ****************
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string what, input logic [DATA_W-1:0] exp,
                     input logic [DATA_W-1:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) begin
      n++;
      if (n > 20) begin
        errors++;
        end_sim();
      end
      @(posedge ref_clk);
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask : bus
  function automatic int exp_high(input int hi, input int lo, input int p);
    int d;
    d = hi * 4 + lo;
    return (d < (p + 1) * 4) ? d : (p + 1) * 4;
  endfunction : exp_high
  // ****************
  // main sequence
  // ****************
  initial begin
    int pa, pb, ch, mode, sel, ps, hi, lo, per, hc, rc, eh;
    logic p0;
    logic [DATA_W-1:0] r0;
    logic [ADDR_W-1:0] base;
    void'($urandom(32'hCDBBFDC3));
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    bus(1'b1, 6'h34, 32'hFFFFFFFF);
    for (int a = 0; a <= 'h34; a += 4) begin
      bus(1'b0, a[ADDR_W-1:0], '0);
      chk("reset value", (a == OFF_PERIOD_A || a == OFF_PERIOD_B) ? 32'(PERIOD_RST) : 32'h0, rd);
    end
    $display("test reset values done");
    bus(1'b1, OFF_CH2_DUTY_HIGH, 32'h000000A5);
    bus(1'b0, OFF_CH2_DUTY_HIGH, '0);
    chk("duty before rollover", 32'h00000000, rd);
    $display("test master latch done");
    pa = $urandom_range(6, 0);
    pb = $urandom_range(6, 0);
    bus(1'b1, OFF_PERIOD_A, 32'(pa));
    bus(1'b1, OFF_PERIOD_B, 32'(pb));
    for (int i = 0; i < 12; i++) begin
      ch = i % 3;
      mode = i % 4;
      sel = (ch == 0) ? 0 : $urandom_range(1, 0);
      ps = (sel == 1) ? pb : pa;
      lo = (mode == 0) ? 0 : $urandom_range(3, 0);
      hi = (mode == 0) ? 0 : (mode == 1) ? ps :
           (mode == 2) ? ps + 1 + $urandom_range(9, 0) : $urandom_range(ps, 0);
      base = OFF_CH1_DUTY_HIGH + ADDR_W'(ch) * CH_STRIDE;
      bus(1'b1, OFF_CTRL, (i < 6) ? 32'h0000003B : 32'h0000003F);
      bus(1'b1, base, 32'(hi));
      bus(1'b1, base + LOW_STEP, 32'(lo * 64 + sel * 32));
      per = (ps + 1) * 4;
      repeat (2 * per + 8) @(posedge ref_clk);
      hc = 0;
      rc = 0;
      p0 = pwm[ch];
      for (int k = 0; k < 4 * per; k++) begin
        @(posedge ref_clk);
        if (pwm[ch] === 1'b1) hc++;
        if (pwm[ch] === 1'b1 && p0 !== 1'b1) rc++;
        p0 = pwm[ch];
      end
      eh = exp_high(hi, lo, ps);
      chk("high clocks", 32'(4 * eh), 32'(hc));
      chk("rises", (eh > 0 && eh < per) ? 32'h4 : 32'h0, 32'(rc));
      bus(1'b0, base, '0);
      chk("duty high", 32'(hi), rd);
      bus(1'b0, base + LOW_STEP, '0);
      chk("duty low", 32'(lo * 64 + sel * 32), rd);
      $display("test pwm trial %0d done", i);
    end
    bus(1'b1, OFF_PERIOD_A, 32'(PERIOD_RST));
    bus(1'b1, OFF_PERIOD_B, 32'(PERIOD_RST));
    bus(1'b1, OFF_CTRL, 32'h00000007);
    bus(1'b0, OFF_TIMER_B, '0);
    r0 = rd;
    repeat (40) @(posedge ref_clk);
    bus(1'b0, OFF_TIMER_B, '0);
    chk("cascaded timer_b", r0, rd);
    $display("test cascade done");
    bus(1'b1, OFF_CTRL, 32'h00000000);
    repeat (3) @(posedge ref_clk);
    chk("irq masked", 32'h0, 32'(irq));
    bus(1'b1, OFF_INT_MASK, 32'h00000003);
    repeat (3) @(posedge ref_clk);
    chk("irq", 32'h1, 32'(irq));
    bus(1'b1, OFF_INT_MASK, 32'h00000000);
    repeat (3) @(posedge ref_clk);
    chk("irq mask off", 32'h0, 32'(irq));
    bus(1'b1, OFF_INT_MASK, 32'h00000003);
    repeat (3) @(posedge ref_clk);
    bus(1'b0, OFF_INT_STATUS, '0);
    chk("flags", 32'h3, rd);
    repeat (3) @(posedge ref_clk);
    chk("irq cleared", 32'h0, 32'(irq));
    bus(1'b0, OFF_INT_STATUS, '0);
    chk("flags cleared", 32'h0, rd);
    $display("test interrupts done");
    end_sim();
  end
endmodule : tcp_tb_top
`default_nettype wire
